// ==== rtl/irq_pkg.sv ====
package irq_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] FLAG_OFS     = 8'h00;  // Maskable request flags
  localparam logic [7:0] MASK_OFS     = 8'h04;  // Mask flags
  localparam logic [7:0] CTRL_OFS     = 8'h08;  // Enable and watchdog mode
  localparam logic [7:0] STAT_OFS     = 8'h0c;  // Live state, read only
  // Control register fields
  localparam int CTRL_IE_BIT  = 0;              // Global interrupt enable
  localparam int CTRL_WIV_BIT = 1;              // Watchdog as interval timer
  // Status register fields
  localparam int STAT_KEY_BIT = 0;              // Key wake pending
  localparam int STAT_WDN_BIT = 1;              // Watchdog NMI pending
  localparam int STAT_ACT_BIT = 2;              // NMI service running
  localparam int STAT_REQ_BIT = 3;              // Request to CPU
  localparam int STAT_VEC_LSB = 16;             // Vector field position
  // Maskable source count and positions, priority equals index
  localparam int NUM_SRC = 5;
  localparam int SRC_WDT = 0;
  localparam int SRC_TM1 = 1;
  localparam int SRC_TM2 = 2;
  localparam int SRC_LVD = 3;
  localparam int SRC_NVW = 4;
  // Reset values
  localparam logic [NUM_SRC-1:0] FLAG_RST = 5'h00;
  localparam logic [NUM_SRC-1:0] MASK_RST = 5'h1f;
  localparam logic [1:0]         CTRL_RST = 2'h0;
  // Sources present in the basic variant
  localparam logic [NUM_SRC-1:0] BASIC_SRC = 5'h07;
  // Vector table addresses
  localparam logic [15:0] VEC_KEY = 16'h0002;
  localparam logic [15:0] VEC_WDT = 16'h0004;
  localparam logic [15:0] VEC_TM1 = 16'h0006;
  localparam logic [15:0] VEC_TM2 = 16'h0008;
  localparam logic [15:0] VEC_LVD = 16'h000a;
  localparam logic [15:0] VEC_NVW = 16'h000c;
  // Winner of the request selection
  typedef enum logic [2:0] {SEL_NONE, SEL_KEY, SEL_WDN, SEL_MASK} sel_kind_t;
endpackage : irq_pkg

// ==== rtl/interrupt_source_and_key_wake.sv ====
// Operation
// - Key pin fall in stop raises wake request
// - Key request unmaskable, stop only, no masks
// - Any key pin low blocks new detection
// - NMI ignores enable and beats maskables
// - Every unmasked request drives the wake signal
// - Two NMI sources: key pins, watchdog
// - Basic variant three sources, nonvolatile five
// - Simultaneous maskables served by priority 0..4
// - Key request is external, vector 0002H
// - Watchdog mode overflow is NMI, vector 0004H
// - Interval watchdog overflow is maskable level 0
// - First timer match level 1, vector 0006H
// - Second timer match level 2, vector 0008H
// - Low voltage level 3, vector 000AH, nonvolatile
// - Write done level 4, vector 000CH, nonvolatile
// - Accept when flag set, mask clear, enabled
// - Acceptance clears the request flag
// - NMI acceptance clears global enable
// - No new NMI until return from interrupt
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
module interrupt_source_and_key_wake #(
  parameter bit NV_VARIANT = 1'b1             // 1 gives the five-source variant
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Source events
  input  wire logic [3:0]  key_input_pin,
  input  wire logic        watchdog_overflow_request,
  input  wire logic        first_timer_match_request,
  input  wire logic        second_timer_match_request,
  input  wire logic        low_voltage_request,
  input  wire logic        nv_write_done_request,
  // CPU side
  input  wire logic        stop_standby,
  input  wire logic        cpu_ack,
  input  wire logic        return_from_interrupt,
  output logic             irq_req,
  output logic             irq_nmi,
  output logic      [15:0] irq_vector,
  output logic             wake
);
  localparam int N = irq_pkg::NUM_SRC;

  // Implemented sources for this variant
  localparam logic [N-1:0] IMPL = NV_VARIANT ? {N{1'b1}} : irq_pkg::BASIC_SRC;

  // Elaboration guard: selection and vector table assume five sources
  if (N != 5) begin : g_bad_count
    $error("Source count must be five");
  end

  // Vector of a maskable source index
  function automatic logic [15:0] vec_of(input int idx);
    case (idx)
      irq_pkg::SRC_WDT: vec_of = irq_pkg::VEC_WDT;
      irq_pkg::SRC_TM1: vec_of = irq_pkg::VEC_TM1;
      irq_pkg::SRC_TM2: vec_of = irq_pkg::VEC_TM2;
      irq_pkg::SRC_LVD: vec_of = irq_pkg::VEC_LVD;
      default:          vec_of = irq_pkg::VEC_NVW;
    endcase
  endfunction : vec_of

  // State
  logic [N-1:0] flag_q;          // Maskable request flags
  logic [N-1:0] mask_q;          // Mask flags, one disables
  logic         ie_q;            // Global interrupt enable
  logic         wiv_q;           // Watchdog in interval mode
  logic         key_nmi_q;       // Key wake pending
  logic         wdt_nmi_q;       // Watchdog NMI pending
  logic         nmi_act_q;       // NMI service running
  logic [3:0]   key_prev_q;      // Key pins last cycle
  logic         lvd_prev_q;      // Low voltage last cycle
  logic         req_q;           // Registered request
  irq_pkg::sel_kind_t kind_q;    // Registered winner kind
  logic [2:0]   idx_q;           // Registered maskable index
  logic [15:0]  vec_q;           // Registered vector

  // Bus pipeline
  logic         dp_wr_q;         // Write in data phase
  logic [7:0]   dp_ofs_q;        // Offset of data phase
  logic [31:0]  rdata_q;         // Read data

  // Source event detection
  logic         key_fall;
  logic [N-1:0] set_ev;
  logic [N-1:0] pend;
  logic         acc;

  // Key fall seen only when all pins were high before
  assign key_fall = stop_standby & (&key_prev_q) & ~(&key_input_pin);

  // Low voltage sets on its rising edge only, so a held low supply sets once
  assign set_ev[irq_pkg::SRC_WDT] = watchdog_overflow_request & wiv_q;
  assign set_ev[irq_pkg::SRC_TM1] = first_timer_match_request;
  assign set_ev[irq_pkg::SRC_TM2] = second_timer_match_request;
  assign set_ev[irq_pkg::SRC_LVD] = low_voltage_request & ~lvd_prev_q;
  assign set_ev[irq_pkg::SRC_NVW] = nv_write_done_request;

  assign pend = flag_q & ~mask_q & IMPL;
  assign acc  = cpu_ack & req_q;

  // Edge history
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      key_prev_q <= 4'hf;
      lvd_prev_q <= 1'b0;
    end else begin
      key_prev_q <= key_input_pin;
      lvd_prev_q <= low_voltage_request;
    end
  end

  // Bus address phase capture
  logic ap_take;
  assign ap_take = hsel & htrans[1] & hready;

  // Data phase tracking; reads are registered, so a read right after a write
  // to the same register returns the old value
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dp_wr_q  <= 1'b0;
      dp_ofs_q <= 8'h00;
    end else begin
      dp_wr_q  <= ap_take & hwrite;
      dp_ofs_q <= haddr[7:0];
    end
  end

  // Write strobes
  logic wr_flag;
  logic wr_mask;
  logic wr_ctrl;
  assign wr_flag = dp_wr_q && (dp_ofs_q == irq_pkg::FLAG_OFS);
  assign wr_mask = dp_wr_q && (dp_ofs_q == irq_pkg::MASK_OFS);
  assign wr_ctrl = dp_wr_q && (dp_ofs_q == irq_pkg::CTRL_OFS);

  // Maskable flags, hardware set wins over write and acceptance clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_q <= irq_pkg::FLAG_RST;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (!IMPL[i]) begin
          flag_q[i] <= 1'b0;                 // Absent source
        end else if (set_ev[i]) begin
          flag_q[i] <= 1'b1;
        end else if (acc && kind_q == irq_pkg::SEL_MASK && idx_q == 3'(i)) begin
          flag_q[i] <= 1'b0;
        end else if (wr_flag) begin
          flag_q[i] <= hwdata[i];
        end
      end
    end
  end

  // Mask flags, absent sources stay masked
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mask_q <= irq_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_q <= hwdata[N-1:0] | ~IMPL;
    end
  end

  // Enable and watchdog mode; acceptance clears enable over a write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ie_q  <= irq_pkg::CTRL_RST[irq_pkg::CTRL_IE_BIT];
      wiv_q <= irq_pkg::CTRL_RST[irq_pkg::CTRL_WIV_BIT];
    end else begin
      if (acc) begin
        ie_q <= 1'b0;
      end else if (wr_ctrl) begin
        ie_q <= hwdata[irq_pkg::CTRL_IE_BIT];
      end
      if (wr_ctrl) begin
        wiv_q <= hwdata[irq_pkg::CTRL_WIV_BIT];
      end
    end
  end

  // Non-maskable pending flags, new event wins over acceptance clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      key_nmi_q <= 1'b0;
      wdt_nmi_q <= 1'b0;
    end else begin
      if (key_fall) begin
        key_nmi_q <= 1'b1;
      end else if (acc && kind_q == irq_pkg::SEL_KEY) begin
        key_nmi_q <= 1'b0;
      end
      if (watchdog_overflow_request && !wiv_q) begin
        wdt_nmi_q <= 1'b1;
      end else if (acc && kind_q == irq_pkg::SEL_WDN) begin
        wdt_nmi_q <= 1'b0;
      end
    end
  end

  // NMI service window, closed by return from interrupt
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nmi_act_q <= 1'b0;
    end else if (acc && (kind_q == irq_pkg::SEL_KEY || kind_q == irq_pkg::SEL_WDN)) begin
      nmi_act_q <= 1'b1;
    end else if (return_from_interrupt) begin
      nmi_act_q <= 1'b0;
    end
  end

  // Selection: NMIs first, then lowest maskable index
  irq_pkg::sel_kind_t kind_d;
  logic [2:0]         idx_d;
  logic [15:0]        vec_d;
  always_comb begin
    kind_d = irq_pkg::SEL_NONE;
    idx_d  = 3'h0;
    vec_d  = 16'h0000;
    if (key_nmi_q && !nmi_act_q) begin
      kind_d = irq_pkg::SEL_KEY;
      vec_d  = irq_pkg::VEC_KEY;
    end else if (wdt_nmi_q && !nmi_act_q) begin
      kind_d = irq_pkg::SEL_WDN;
      vec_d  = irq_pkg::VEC_WDT;
    end else if (ie_q && (|pend)) begin
      kind_d = irq_pkg::SEL_MASK;
      for (int i = N - 1; i >= 0; i--) begin
        if (pend[i]) begin
          idx_d = 3'(i);
          vec_d = vec_of(i);
        end
      end
    end
  end

  // Request register; dropped for one cycle after acceptance so the
  // cleared flag settles before the next pick
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_q  <= 1'b0;
      kind_q <= irq_pkg::SEL_NONE;
      idx_q  <= 3'h0;
      vec_q  <= 16'h0000;
    end else begin
      req_q  <= (kind_d != irq_pkg::SEL_NONE) && !acc;
      kind_q <= acc ? irq_pkg::SEL_NONE : kind_d;
      idx_q  <= idx_d;
      vec_q  <= vec_d;
    end
  end

  // Wake on any pending request, whatever the enable
  logic wake_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= key_nmi_q | wdt_nmi_q | (|pend);
    end
  end

  // Register read, unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      rdata_q <= 32'h0000_0000;
      if (haddr[7:0] == irq_pkg::FLAG_OFS) begin
        rdata_q[N-1:0] <= flag_q;
      end else if (haddr[7:0] == irq_pkg::MASK_OFS) begin
        rdata_q[N-1:0] <= mask_q;
      end else if (haddr[7:0] == irq_pkg::CTRL_OFS) begin
        rdata_q[irq_pkg::CTRL_IE_BIT]  <= ie_q;
        rdata_q[irq_pkg::CTRL_WIV_BIT] <= wiv_q;
      end else if (haddr[7:0] == irq_pkg::STAT_OFS) begin
        rdata_q[irq_pkg::STAT_KEY_BIT] <= key_nmi_q;
        rdata_q[irq_pkg::STAT_WDN_BIT] <= wdt_nmi_q;
        rdata_q[irq_pkg::STAT_ACT_BIT] <= nmi_act_q;
        rdata_q[irq_pkg::STAT_REQ_BIT] <= req_q;
        rdata_q[irq_pkg::STAT_VEC_LSB +: 16] <= vec_q;
      end
    end
  end

  // Outputs
  assign hrdata     = rdata_q;
  assign hreadyout  = 1'b1;                  // Zero wait states
  assign hresp      = 1'b0;                  // Always OKAY
  assign irq_req    = req_q;
  assign irq_nmi    = req_q && (kind_q == irq_pkg::SEL_KEY || kind_q == irq_pkg::SEL_WDN);
  assign irq_vector = vec_q;
  assign wake       = wake_q;

  // Checks
  sequence s_accept;
    acc ##1 1'b1;
  endsequence

  property p_key_fall;
    @(posedge sys_clk) disable iff (!rst_n)
      key_fall |=> key_nmi_q;
  endproperty
  a_key_fall: assert property (p_key_fall) else $error("Key fall lost");

  property p_key_stop;
    @(posedge sys_clk) disable iff (!rst_n)
      (!stop_standby && !key_nmi_q) |=> !key_nmi_q;
  endproperty
  a_key_stop: assert property (p_key_stop) else $error("Key set outside stop");

  property p_key_held;
    @(posedge sys_clk) disable iff (!rst_n)
      (!(&key_prev_q) && !key_nmi_q) |=> !key_nmi_q;
  endproperty
  a_key_held: assert property (p_key_held) else $error("Key set while pin low");

  property p_nmi_first;
    @(posedge sys_clk) disable iff (!rst_n)
      (key_nmi_q && !nmi_act_q && !acc) |=> (irq_nmi && irq_vector == irq_pkg::VEC_KEY);
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("Key NMI not first");

  property p_wake;
    @(posedge sys_clk) disable iff (!rst_n)
      (|pend) |=> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("No wake on request");

  property p_prio;
    @(posedge sys_clk) disable iff (!rst_n)
      // Index was picked from last cycle's pending set, so judge against that
      (req_q && kind_q == irq_pkg::SEL_MASK) |->
        ($past(pend) & ((5'h01 << idx_q) - 5'h01)) == 5'h00;
  endproperty
  a_prio: assert property (p_prio) else $error("Lower level served first");

  property p_ack_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (acc && kind_q == irq_pkg::SEL_MASK && !set_ev[idx_q]) |=> !flag_q[$past(idx_q)];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("Flag kept on accept");

  property p_ie_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      s_accept |-> !ie_q && !req_q;
  endproperty
  a_ie_clear: assert property (p_ie_clear) else $error("Enable kept on accept");

  property p_nmi_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (nmi_act_q && !return_from_interrupt) |=> !irq_nmi;
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("NMI during service");

  property p_masked;
    @(posedge sys_clk) disable iff (!rst_n)
      (!ie_q && !key_nmi_q && !wdt_nmi_q) |=> !irq_req;
  endproperty
  a_masked: assert property (p_masked) else $error("Maskable while disabled");
endmodule : interrupt_source_and_key_wake

// ==== tb/cpu_core_model.sv ====
module cpu_core_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Knobs set by the bench
  input  wire logic        ack_en,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        return_from_interrupt_en,
  // Interrupt link
  input  wire logic        irq_req,
  input  wire logic        irq_nmi,
  input  wire logic [15:0] irq_vector,
  output logic             cpu_ack,
  output logic             return_from_interrupt,
  // Record of the last acceptance
  output logic [15:0]      acc_vec,
  output logic             acc_nmi,
  output logic [7:0]       acc_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;  // Cycles the request has waited
  logic       nmi_q;   // Inside a non-maskable service routine

  // Acknowledge after a chosen delay, one cycle wide
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cpu_ack <= 1'b0;
      wait_q  <= 4'h0;
    end else if (cpu_ack || !(ack_en && irq_req)) begin
      // One acknowledge per request, so a dropped request is never taken twice
      cpu_ack <= 1'b0;
      wait_q  <= 4'h0;
    end else if (wait_q >= ack_delay) begin
      cpu_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // Capture what was taken at the accepting edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_vec <= 16'h0000;
      acc_nmi <= 1'b0;
      acc_cnt <= 8'h00;
    end else if (cpu_ack && irq_req) begin
      acc_vec <= irq_vector;
      acc_nmi <= irq_nmi;
      acc_cnt <= acc_cnt + 8'h01;
    end
  end

  // NMI service routine ends with a return; held back while the bench says so
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nmi_q                 <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else if (cpu_ack && irq_req && irq_nmi) begin
      nmi_q                 <= 1'b1;
      return_from_interrupt <= 1'b0;
    end else if (return_from_interrupt) begin
      return_from_interrupt <= 1'b0;
    end else if (nmi_q && return_from_interrupt_en) begin
      return_from_interrupt <= 1'b1;
      nmi_q                 <= 1'b0;
    end
  end
endmodule : cpu_core_model

// ==== tb/interrupt_source_and_key_wake_tb.sv ====
module interrupt_source_and_key_wake_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Bus master side
  logic        sys_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, hrdata_b;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  // Sources and CPU link
  logic [3:0]  key_input_pin;
  logic        watchdog_overflow_request, first_timer_match_request;
  logic        second_timer_match_request, low_voltage_request, nv_write_done_request;
  logic        stop_standby, cpu_ack, return_from_interrupt, irq_req, irq_nmi, wake;
  logic [15:0] irq_vector, acc_vec;
  logic        ack_en, return_from_interrupt_en, acc_nmi;
  logic [3:0]  ack_delay;
  logic [7:0]  acc_cnt;
  int          miscompares, checks;
  // Expected vectors in priority order 0..4
  localparam logic [15:0] VECS [5] = '{irq_pkg::VEC_WDT, irq_pkg::VEC_TM1,
    irq_pkg::VEC_TM2, irq_pkg::VEC_LVD, irq_pkg::VEC_NVW};

  interrupt_source_and_key_wake u_dut (
    .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .key_input_pin, .watchdog_overflow_request,
    .first_timer_match_request, .second_timer_match_request, .low_voltage_request,
    .nv_write_done_request, .stop_standby, .cpu_ack, .return_from_interrupt,
    .irq_req, .irq_nmi, .irq_vector, .wake);
  // Basic variant shares bus and sources; never acknowledged
  interrupt_source_and_key_wake #(.NV_VARIANT(1'b0)) u_basic (
    .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata(hrdata_b), .hreadyout(), .hresp(), .key_input_pin, .watchdog_overflow_request,
    .first_timer_match_request, .second_timer_match_request, .low_voltage_request,
    .nv_write_done_request, .stop_standby, .cpu_ack(1'b0), .return_from_interrupt(1'b0),
    .irq_req(), .irq_nmi(), .irq_vector(), .wake());
  cpu_core_model u_cpu (.sys_clk, .rst_n, .ack_en, .ack_delay, .return_from_interrupt_en, .irq_req, .irq_nmi,
    .irq_vector, .cpu_ack, .return_from_interrupt, .acc_vec, .acc_nmi, .acc_cnt);

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    checks++;
    if (got !== e) begin
      $display("unexpected %s: expected %h, seen %h", what, e, got);
      miscompares++;
    end
  endtask : chk

  // One single word transfer; the slave's answer is awaited, not assumed
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd, output logic [31:0] rdb);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, ofs};
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd  = hrdata;
    rdb = hrdata_b;
  endtask : bus

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] a, b;
    bus(1'b1, ofs, d, a, b);
  endtask : wr

  task automatic rc(input string what, input logic [7:0] ofs, input logic [31:0] e,
                    input logic [31:0] eb);
    logic [31:0] a, b;
    bus(1'b0, ofs, 32'h00000000, a, b);
    chk(what, e, a);
    chk({what, " basic"}, eb, b);
  endtask : rc

  // Pulse sources, bit order wdt, tm1, tm2, lvd, nvw
  task automatic pulse(input logic [4:0] v);
    @(posedge sys_clk);
    {nv_write_done_request, low_voltage_request, second_timer_match_request,
     first_timer_match_request, watchdog_overflow_request} <= v;
    @(posedge sys_clk);
    {nv_write_done_request, low_voltage_request, second_timer_match_request,
     first_timer_match_request, watchdog_overflow_request} <= 5'h00;
  endtask : pulse

  task automatic key(input logic [3:0] v, input logic stop);
    @(posedge sys_clk);
    key_input_pin <= v;
    stop_standby  <= stop;
  endtask : key

  // Wait for the CPU model to accept, bounded
  task automatic take(input string what, input logic [15:0] vec, input logic nmi);
    logic [7:0] start;
    int         n;
    start = acc_cnt;
    n = 0;
    while (acc_cnt === start && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk({what, " taken"}, 32'h1, 32'(acc_cnt !== start));
    chk({what, " vector"}, 32'(vec), 32'(acc_vec));
    chk({what, " nmi"}, 32'(nmi), 32'(acc_nmi));
  endtask : take

  // Nothing may be presented; request latency is two cycles
  task automatic quiet(input string what);
    logic [7:0] start;
    start = acc_cnt;
    repeat (8) @(negedge sys_clk);
    chk({what, " irq_req"}, 32'h0, 32'(irq_req));
    chk({what, " accepts"}, 32'(start), 32'(acc_cnt));
  endtask : quiet

  task automatic test_reset;
    rc("flag", irq_pkg::FLAG_OFS, 32'h00, 32'h00);
    rc("mask", irq_pkg::MASK_OFS, 32'h1f, 32'h1f);
    rc("ctrl", irq_pkg::CTRL_OFS, 32'h00, 32'h00);
    wr(irq_pkg::STAT_OFS, 32'hffffffff);
    rc("status", irq_pkg::STAT_OFS, 32'h00, 32'h00);
    wr(8'h10, 32'hffffffff);
    rc("unmapped", 8'h10, 32'h00, 32'h00);
    chk("hresp", 32'h0, 32'(hresp));
    $display("test reset done");
  endtask : test_reset

  task automatic test_priority;
    wr(irq_pkg::MASK_OFS, 32'h00);
    wr(irq_pkg::CTRL_OFS, 32'h03);
    rc("mask", irq_pkg::MASK_OFS, 32'h00, 32'h18);
    ack_en <= 1'b1;
    pulse(5'h1f);
    for (int i = 0; i < 5; i++) begin
      take("level", VECS[i], 1'b0);
      rc("flag", irq_pkg::FLAG_OFS, 32'h1f & (32'h1f << (i + 1)), 32'h07);
      chk("wake", 32'(i < 4), 32'(wake));
      chk("held", 32'h0, 32'(irq_req));
      wr(irq_pkg::CTRL_OFS, 32'h03);
    end
    $display("test priority done");
  endtask : test_priority

  task automatic test_mask;
    ack_delay <= 4'h3;
    wr(irq_pkg::MASK_OFS, 32'h1f);
    pulse(5'h02);
    quiet("masked");
    chk("masked wake", 32'h0, 32'(wake));
    wr(irq_pkg::MASK_OFS, 32'h00);
    take("unmasked", irq_pkg::VEC_TM1, 1'b0);
    ack_delay <= 4'h0;
    $display("test mask done");
  endtask : test_mask

  task automatic test_key;
    wr(irq_pkg::CTRL_OFS, 32'h00);
    return_from_interrupt_en <= 1'b0;
    key(4'he, 1'b0);
    quiet("run mode");
    key(4'he, 1'b1);
    key(4'hc, 1'b1);
    quiet("pin low");
    key(4'hf, 1'b1);
    key(4'hb, 1'b1);
    take("key", irq_pkg::VEC_KEY, 1'b1);
    key(4'hf, 1'b1);
    pulse(5'h01);
    quiet("in service");
    return_from_interrupt_en <= 1'b1;
    take("watchdog", irq_pkg::VEC_WDT, 1'b1);
    $display("test key done");
  endtask : test_key

  task automatic test_nmi_wins;
    wr(irq_pkg::CTRL_OFS, 32'h01);
    ack_en <= 1'b0;
    @(posedge sys_clk);
    second_timer_match_request <= 1'b1;
    key_input_pin              <= 4'h7;
    @(posedge sys_clk);
    second_timer_match_request <= 1'b0;
    repeat (6) @(posedge sys_clk);
    ack_en <= 1'b1;
    take("first", irq_pkg::VEC_KEY, 1'b1);
    key(4'hf, 1'b0);
    wr(irq_pkg::CTRL_OFS, 32'h01);
    take("second", irq_pkg::VEC_TM2, 1'b0);
    $display("test nmi wins done");
  endtask : test_nmi_wins

  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // Main sequence: 20 cycles of reset, then the scenarios
  initial begin
    miscompares = 0;
    checks = 0;
    rst_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    key_input_pin = 4'hf;
    {nv_write_done_request, low_voltage_request, second_timer_match_request,
     first_timer_match_request, watchdog_overflow_request} = 5'h00;
    {stop_standby, ack_en, ack_delay} = '0;
    return_from_interrupt_en = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    test_reset();
    test_priority();
    test_mask();
    test_key();
    test_nmi_wins();
    results();
  end

  // Hang guard, far beyond the expected run of about two hundred cycles
  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule : interrupt_source_and_key_wake_tb
